/* logic/tmrc_consts.vh */
// register map, field positions, reset values and timing figures of the timer/counter
`ifndef TMRC_CONSTS_VH
`define TMRC_CONSTS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define TMRC_ADDR_W        8
`define TMRC_OFS_CTRL      8'h10
`define TMRC_OFS_CNT_LO    8'h14
`define TMRC_OFS_CNT_HI    8'h18
`define TMRC_OFS_IRQ_STAT  8'h1C
`define TMRC_OFS_IRQ_CLR   8'h20
`define TMRC_OFS_IRQ_EN    8'h24

// ----------------------------------------
// timer_control fields
// ----------------------------------------
`define TMRC_CTRL_ON       0
`define TMRC_CTRL_CS       1
`define TMRC_CTRL_SYNCDIS  2
`define TMRC_CTRL_OSCEN    3
`define TMRC_CTRL_PS_LO    4
`define TMRC_CTRL_PS_HI    5
`define TMRC_CTRL_MASK     8'h3F
`define TMRC_CTRL_RST      8'h00

// ----------------------------------------
// interrupt fields and counter values
// ----------------------------------------
`define TMRC_IRQ_OVF       0
`define TMRC_CNT_RST       16'h0000
`define TMRC_CNT_MAX       16'hFFFF
`define TMRC_PS_W          3
`define TMRC_SYNC_STAGES   3

`endif

/* logic/tmrc_prescale.v */
// input prescaler of the timer/counter: divides the count steps by 1, 2, 4 or 8
`include "tmrc_consts.vh"

module tmrc_prescale
#(
   parameter PS_W = `TMRC_PS_W
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clr,
   input  wire        step,
   input  wire [1:0]  ratio_sel,
   output wire        tick
);

   // ----------------------------------------
   // ratio decode
   // ----------------------------------------
   function [PS_W-1:0] ratio_mask;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   ratio_mask = 3'h0;
            2'b01:   ratio_mask = 3'h1;
            2'b10:   ratio_mask = 3'h3;
            default: ratio_mask = 3'h7;
         endcase
      end
   endfunction

   reg  [PS_W-1:0] pre_r;
   wire [PS_W-1:0] mask;

   assign mask = ratio_mask(ratio_sel);
   // a step that fills the selected low bits passes on as one tick
   assign tick = step & ((pre_r & mask) == mask);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_r <= 3'h0;
      else if (clr)
         pre_r <= 3'h0;
      else if (step)
         pre_r <= pre_r + 3'h1;
   end

endmodule // tmrc_prescale

/* logic/tmrc_timer.v */
// sixteen-bit timer/counter with apb registers, overflow interrupt and oscillator pin control
//
// Behaviour
// - count held as readable writable high, low bytes
// - count climbs to all ones, wraps to zero
// - each wrap latches overflow flag until cleared
// - interrupt request only while enable bit set
// - clock source select alone picks timer/counter
// - timer mode counts instruction cycles, then prescaled
// - counter mode counts external rising edges only
// - counts only while timer_on set, else holds
// - capture compare unit reset input clears count
// - oscillator enable forces both oscillator pins input
// - sync_disable zero synchronises external edges, one bypasses
// - internal clock ignores sync_disable completely
// - internal clock is oscillator over four, pclk
// - edge from oscillator pin or external pin
//
// Design decision made here: the APB register port.
`include "tmrc_consts.vh"

module tmrc_timer
#(
   parameter CNT_W = 16
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        ext_clock_pin,
   input  wire        osc_input_pin,
   input  wire [1:0]  port_b_direction,
   input  wire [1:0]  port_b_out,
   input  wire        ccu_reset,
   output reg  [1:0]  port_b_pin_out,
   output reg  [1:0]  port_b_pin_oe,
   output reg         osc_power_en,
   output reg         irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [7:0]       timer_control_r;
   reg  [CNT_W-1:0] count_r;
   reg  [CNT_W-1:0] count_nxt;
   reg              overflow_flag_r;
   reg              overflow_irq_enable_r;
   reg  [`TMRC_SYNC_STAGES-1:0] ext_sync_r;
   reg  [`TMRC_SYNC_STAGES-1:0] osc_sync_r;
   reg              ext_lvl_r;
   reg              osc_lvl_r;
   reg              tick_late_r;
   wire             timer_on;
   wire             clock_source_select;
   wire             sync_disable;
   wire             osc_enable;
   wire [1:0]       input_prescale_select;
   wire             ext_rise;
   wire             osc_rise;
   wire             pin_rise;
   wire             step;
   wire             tick;
   wire             inc;
   wire             wrap;
   wire             acc;
   wire             wr;
   wire             wr_lo;
   wire             wr_hi;
   wire             wr_ctrl;
   wire             wr_clr;
   wire             wr_en;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function mapped;
      input [7:0] a;
      begin
         case (a)
            `TMRC_OFS_CTRL,
            `TMRC_OFS_CNT_LO,
            `TMRC_OFS_CNT_HI,
            `TMRC_OFS_IRQ_STAT,
            `TMRC_OFS_IRQ_CLR,
            `TMRC_OFS_IRQ_EN: mapped = 1'b1;
            default:          mapped = 1'b0;
         endcase
      end
   endfunction

   // one wait state: pready rises in the second access cycle
   assign acc     = psel & penable & pready;
   assign wr      = acc & pwrite;
   assign wr_ctrl = wr & (paddr == `TMRC_OFS_CTRL);
   assign wr_lo   = wr & (paddr == `TMRC_OFS_CNT_LO);
   assign wr_hi   = wr & (paddr == `TMRC_OFS_CNT_HI);
   assign wr_clr  = wr & (paddr == `TMRC_OFS_IRQ_CLR);
   assign wr_en   = wr & (paddr == `TMRC_OFS_IRQ_EN);

   // ----------------------------------------
   // control fields
   // ----------------------------------------
   assign timer_on              = timer_control_r[`TMRC_CTRL_ON];
   assign clock_source_select   = timer_control_r[`TMRC_CTRL_CS];
   assign sync_disable          = timer_control_r[`TMRC_CTRL_SYNCDIS];
   assign osc_enable            = timer_control_r[`TMRC_CTRL_OSCEN];
   assign input_prescale_select = timer_control_r[`TMRC_CTRL_PS_HI:`TMRC_CTRL_PS_LO];

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_control_r <= `TMRC_CTRL_RST;
      else if (wr_ctrl)
         timer_control_r <= pwdata[7:0] & `TMRC_CTRL_MASK;
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // a level is believed once the second and third stage agree
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_sync_r <= 3'h0;
         osc_sync_r <= 3'h0;
         ext_lvl_r  <= 1'b0;
         osc_lvl_r  <= 1'b0;
      end
      else
      begin
         ext_sync_r <= {ext_sync_r[1:0], ext_clock_pin};
         osc_sync_r <= {osc_sync_r[1:0], osc_input_pin};
         if (ext_sync_r[1] == ext_sync_r[2])
            ext_lvl_r <= ext_sync_r[2];
         if (osc_sync_r[1] == osc_sync_r[2])
            osc_lvl_r <= osc_sync_r[2];
      end
   end

   // falling edges never produce a step
   assign ext_rise = ext_sync_r[1] & ext_sync_r[2] & ~ext_lvl_r;
   assign osc_rise = osc_sync_r[1] & osc_sync_r[2] & ~osc_lvl_r;
   assign pin_rise = osc_enable ? osc_rise : ext_rise;

   // ----------------------------------------
   // step source and prescaler
   // ----------------------------------------
   // pclk stands for the instruction clock, so every cycle is a timer step
   assign step = timer_on & (clock_source_select ? pin_rise : 1'b1);

   tmrc_prescale
   #(
      .PS_W      (`TMRC_PS_W)
   )
   u_prescale
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .clr       (wr_lo | wr_hi),
      .step      (step),
      .ratio_sel (input_prescale_select),
      .tick      (tick)
   );

   // synchronised counting re-times the prescaled tick by one more cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_late_r <= 1'b0;
      else
         tick_late_r <= tick & clock_source_select & ~sync_disable & timer_on;
   end

   // internal clock never looks at sync_disable
   assign inc = clock_source_select ? (sync_disable ? tick : tick_late_r) : tick;

   // ----------------------------------------
   // count register pair
   // ----------------------------------------
   assign wrap = inc & ~ccu_reset & (count_r == `TMRC_CNT_MAX);

   // a register write beats the capture compare reset, which beats counting
   always @*
   begin
      count_nxt = count_r;
      if (wr_lo | wr_hi)
      begin
         if (wr_lo)
            count_nxt[7:0] = pwdata[7:0];
         if (wr_hi)
            count_nxt[15:8] = pwdata[7:0];
      end
      else if (ccu_reset)
         count_nxt = `TMRC_CNT_RST;
      else if (inc)
         count_nxt = count_r + 16'h0001;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= `TMRC_CNT_RST;
      else
         count_r <= count_nxt;
   end

   // ----------------------------------------
   // overflow flag and interrupt
   // ----------------------------------------
   // a wrap in the clearing cycle keeps the flag set
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overflow_flag_r <= 1'b0;
      else if (wrap)
         overflow_flag_r <= 1'b1;
      else if (wr_clr & pwdata[`TMRC_IRQ_OVF])
         overflow_flag_r <= 1'b0;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overflow_irq_enable_r <= 1'b0;
      else if (wr_en)
         overflow_irq_enable_r <= pwdata[`TMRC_IRQ_OVF];
   end

   // the enable gates only the request, never the flag
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= overflow_flag_r & overflow_irq_enable_r;
   end

   // ----------------------------------------
   // oscillator pins
   // ----------------------------------------
   // direction bits are ignored while the oscillator owns the pins
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_b_pin_oe  <= 2'h0;
         port_b_pin_out <= 2'h0;
         osc_power_en   <= 1'b0;
      end
      else
      begin
         port_b_pin_oe  <= osc_enable ? 2'h0 : ~port_b_direction;
         port_b_pin_out <= port_b_out;
         osc_power_en   <= osc_enable;
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (psel & penable & ~pready)
      begin
         pready  <= 1'b1;
         pslverr <= ~mapped(paddr);
         prdata  <= 32'h0000_0000;
         if (~pwrite)
         begin
            case (paddr)
               `TMRC_OFS_CTRL:     prdata <= {24'h000000, timer_control_r};
               `TMRC_OFS_CNT_LO:   prdata <= {24'h000000, count_r[7:0]};
               `TMRC_OFS_CNT_HI:   prdata <= {24'h000000, count_r[15:8]};
               `TMRC_OFS_IRQ_STAT: prdata <= {31'h00000000, overflow_flag_r};
               `TMRC_OFS_IRQ_EN:   prdata <= {31'h00000000, overflow_irq_enable_r};
               default:            prdata <= 32'h0000_0000;
            endcase
         end
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule // tmrc_timer

/* testbench/tmrc_clk_src.sv */
// far-side model: external count clock or oscillator input, square pulses on one pin
module tmrc_clk_src
#(
   parameter HALF = 4
)
(
   input  logic       pclk,
   input  logic       run,
   input  logic       sel_osc,
   output logic       ext_clock_pin,
   output logic       osc_input_pin,
   output logic [7:0] n_edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       lvl_r = 1'h0;
   logic [3:0] ph_r  = 4'h0;
   initial n_edges = 8'h00;
   // ---------------------------------------------
   // pulse maker
   // ---------------------------------------------
   // stands still low between bursts; a burst ends only after a full high phase
   always @(posedge pclk)
   begin
      if (!run && !lvl_r)
      begin
         ph_r    <= 4'h0;
         n_edges <= 8'h00;
      end
      else if (ph_r == 4'(HALF - 1))
      begin
         ph_r    <= 4'h0;
         lvl_r   <= !lvl_r;
         n_edges <= n_edges + {7'h00, !lvl_r};
      end
      else
         ph_r <= ph_r + 4'h1;
   end
   // only the selected pin moves, the other rests low
   assign ext_clock_pin = lvl_r & !sel_osc;
   assign osc_input_pin = lvl_r & sel_osc;
endmodule // tmrc_clk_src

/* testbench/tmrc_properties.sv */
// port relations of the timer/counter checked as concurrent assertions
`include "tmrc_consts.vh"
module tmrc_props
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [1:0]  port_b_direction,
   input logic [1:0]  port_b_pin_oe,
   input logic        osc_power_en,
   input logic        irq
);
   wire wr = psel & penable & pready & pwrite;
   wire rd = psel & penable & pready & !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_done; psel && penable && pready; endsequence
   property p_rdy; s_wait |=> s_done; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_clr0; rd && paddr == `TMRC_OFS_IRQ_CLR |-> prdata == 32'h0; endproperty
   property p_ctrl; rd && paddr == `TMRC_OFS_CTRL |-> prdata[31:6] == 26'h0; endproperty
   // control lands at the write edge, the power output one edge later
   property p_pwr; wr && paddr == `TMRC_OFS_CTRL |=> ##1 osc_power_en == $past(pwdata[3], 2); endproperty
   property p_osc; osc_power_en && $past(osc_power_en) |-> port_b_pin_oe == 2'h0; endproperty
   // the first edge after release still shows the reset value of the enables
   property p_pin; $past(presetn) && !osc_power_en && !$past(osc_power_en) |->
      port_b_pin_oe == ~$past(port_b_direction);
   endproperty
   property p_irqoff; wr && paddr == `TMRC_OFS_IRQ_EN && !pwdata[0] |-> ##[1:2] !irq; endproperty
   a_rdy: assert property (p_rdy) else $error("pready not one cycle after access");
   a_one: assert property (p_one) else $error("pready longer than one cycle");
   a_err: assert property (p_err) else $error("pslverr without pready");
   a_clr0: assert property (p_clr0) else $error("clear register read not zero");
   a_ctrl: assert property (p_ctrl) else $error("control upper bits not zero");
   a_pwr: assert property (p_pwr) else $error("oscillator power not following enable");
   a_osc: assert property (p_osc) else $error("oscillator pins driven");
   a_pin: assert property (p_pin) else $error("pin enable not from direction");
   a_irqoff: assert property (p_irqoff) else $error("irq stays with enable off");
endmodule // tmrc_props

/* testbench/tb_top.sv */
// top testbench of the timer/counter: register rows, timer, irq, reset input and counter cases
`include "tmrc_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} tmrc_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, osc_power_en, ccu_reset;
   logic        ext_clock_pin, osc_input_pin, run, sel_osc, e;
   logic [7:0]  paddr, n_edges;
   logic [31:0] pwdata, prdata, q, h;
   logic [1:0]  port_b_direction, port_b_out, port_b_pin_out, port_b_pin_oe;
   int          num_errors, samples_checked, cyc, n;
   tmrc_row_t   rows [7] = '{'{`TMRC_OFS_CTRL, 32'hFFFFFFFE, 32'h3E, 1'h0},
      '{`TMRC_OFS_CNT_LO, 32'h1A5, 32'hA5, 1'h0}, '{`TMRC_OFS_CNT_HI, 32'h5A, 32'h5A, 1'h0},
      '{`TMRC_OFS_IRQ_EN, 32'hFF, 32'h1, 1'h0}, '{`TMRC_OFS_IRQ_STAT, 32'h1, 32'h0, 1'h0},
      '{`TMRC_OFS_IRQ_CLR, 32'h1, 32'h0, 1'h0}, '{8'h40, 32'h5, 32'h0, 1'h1}};
   tmrc_timer u_tmrc_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ext_clock_pin, .osc_input_pin, .port_b_direction, .port_b_out, .ccu_reset, .port_b_pin_out,
      .port_b_pin_oe, .osc_power_en, .irq);
   tmrc_clk_src u_tmrc_clk_src (.pclk, .run, .sel_osc, .ext_clock_pin, .osc_input_pin, .n_edges);
   // ---------------------------------------------
   // bus, compare and closing tasks
   // ---------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic chk(string s, logic [31:0] x, logic [31:0] g);
      samples_checked++;
      if (g !== x)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic results;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      pclk = 1'h0;
      forever #25 pclk = !pclk;
   end
   // hang guard: whole run needs under a thousand cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         results();
      end
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, ccu_reset, run, sel_osc} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      port_b_direction = 2'h0;
      port_b_out = 2'h2;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'h0, 8'(8'h10 + 4 * i), 32'h0);
         chk("reset value", 32'h0, q);
      end
      foreach (rows[i])
      begin
         apb(1'h1, rows[i].a, rows[i].d);
         chk("write error", 32'(rows[i].e), 32'(e));
         apb(1'h0, rows[i].a, 32'h0);
         chk("read back", rows[i].x, q);
      end
      $display("test registers done");
      // window allows for prescaler and irq pipeline lag
      for (int p = 0; p < 4; p++)
      begin
         apb(1'h1, `TMRC_OFS_CTRL, 32'h0);
         apb(1'h1, `TMRC_OFS_CNT_LO, 32'hF0);
         apb(1'h1, `TMRC_OFS_CNT_HI, 32'hFF);
         apb(1'h1, `TMRC_OFS_IRQ_CLR, 32'h1);
         apb(1'h1, `TMRC_OFS_CTRL, 32'(p * 20 + 1));
         n = 0;
         while (irq !== 1'h1)
         begin
            @(posedge pclk);
            n++;
         end
         chk("wrap time ok", 32'h1, 32'(n >= (16 << p) - 2 && n <= (16 << p) + 6));
         apb(1'h1, `TMRC_OFS_CTRL, 32'h0);
         apb(1'h0, `TMRC_OFS_IRQ_STAT, 32'h0);
         chk("overflow flag", 32'h1, q);
         apb(1'h0, `TMRC_OFS_CNT_HI, 32'h0);
         chk("wrapped high byte", 32'h0, q);
      end
      apb(1'h0, `TMRC_OFS_CNT_LO, 32'h0);
      h = q;
      repeat (20) @(posedge pclk);
      apb(1'h0, `TMRC_OFS_CNT_LO, 32'h0);
      chk("held count", h, q);
      $display("test timer done");
      apb(1'h1, `TMRC_OFS_IRQ_EN, 32'h0);
      repeat (2) @(posedge pclk);
      chk("masked irq", 32'h0, 32'(irq));
      apb(1'h0, `TMRC_OFS_IRQ_STAT, 32'h0);
      chk("flag kept", 32'h1, q);
      apb(1'h1, `TMRC_OFS_IRQ_EN, 32'h1);
      repeat (2) @(posedge pclk);
      chk("enabled irq", 32'h1, 32'(irq));
      apb(1'h1, `TMRC_OFS_IRQ_CLR, 32'h1);
      repeat (2) @(posedge pclk);
      chk("cleared irq", 32'h0, 32'(irq));
      apb(1'h1, `TMRC_OFS_CNT_LO, 32'h80);
      ccu_reset <= 1'h1;
      @(posedge pclk);
      ccu_reset <= 1'h0;
      apb(1'h0, `TMRC_OFS_CNT_LO, 32'h0);
      chk("count after reset input", 32'h0, q);
      apb(1'h0, `TMRC_OFS_IRQ_STAT, 32'h0);
      chk("flag after reset input", 32'h0, q);
      $display("test irq done");
      for (int m = 0; m < 4; m++)
      begin
         apb(1'h1, `TMRC_OFS_CTRL, 32'h0);
         apb(1'h1, `TMRC_OFS_CNT_LO, 32'h0);
         sel_osc <= m[1];
         apb(1'h1, `TMRC_OFS_CTRL, 32'(3 + 4 * m));
         run <= 1'h1;
         while (n_edges != 8'h05) @(posedge pclk);
         run <= 1'h0;
         repeat (20) @(posedge pclk);
         apb(1'h0, `TMRC_OFS_CNT_LO, 32'h0);
         chk("rising edges counted", 32'h5, q);
      end
      chk("pin output level", 32'h2, 32'(port_b_pin_out));
      chk("pins released to oscillator", 32'h0, 32'(port_b_pin_oe));
      chk("oscillator powered", 32'h1, 32'(osc_power_en));
      $display("test counter done");
      results();
   end
endmodule // tb_top
bind tmrc_timer tmrc_props u_tmrc_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .port_b_direction, .port_b_pin_oe, .osc_power_en, .irq);
